//--- include/sac_pkg.sv
// Package of constants for the successive-approximation conversion control.
// Assumes a single 25 MHz core clock and a converter clock enable input.
`default_nettype none
package sac_pkg;
    // Width of the result code
    localparam int RES_W = 8;
    // Core clock cycles per internal phase step (converter clock divide)
    localparam int PHASE_DIV = 8;
    // Converter clock periods for one full search (8 bits x 8)
    localparam int CONV_CYCLES = 64;
    // Converter clock periods the done set input stays active
    localparam int DONE_SET_CYCLES = 8;
    // Result code when the negative input is not below the positive
    localparam logic [7:0] ZERO_CODE = 8'h00;
    // Reset value of the held result
    localparam logic [7:0] RESULT_RST = 8'h00;
    // Full scale code
    localparam logic [7:0] FULL_CODE = 8'hFF;
    // Longest allowed self-start done pulse in free-running mode, ns
    localparam int FREE_PULSE_NS = 300;
    // Core clock period in ns
    localparam int CLK_PERIOD_NS = 40;
    // Free-running done pulse in core cycles, rounded down, at least one
    localparam int FREE_PULSE_CYC = (FREE_PULSE_NS / CLK_PERIOD_NS) < 1 ?
        1 : (FREE_PULSE_NS / CLK_PERIOD_NS);
endpackage
`default_nettype wire

//--- hw/sac_ctrl.sv
// Conversion control of an 8-bit successive-approximation converter.
// Assumes host strobes synchronous to core_clk; the comparator is outside
// and answers each trial code on cmp_high within the same converter step.
`default_nettype none

module sac_ctrl #(
    parameter int PHASE_DIV = sac_pkg::PHASE_DIV // Clocks per step
) (
    input wire logic core_clk, // Converter clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic select_n, // Chip select, active low
    input wire logic start_n, // Start strobe, active low
    input wire logic read_n, // Read strobe, active low
    input wire logic cmp_high, // Comparator: input at or above trial level
    input wire logic neg_ge_pos, // Negative input at or above positive
    output logic [7:0] trial_code_q, // Trial code to the ladder
    output logic [7:0] data_out_q, // Result onto the data lines
    output logic data_oe_q, // Data lines driven while high
    output logic conversion_done_n_q // End of conversion, active low
);
    // ****************************************************
    // Internal state
    // ****************************************************
    typedef enum logic [1:0] {SAC_IDLE, SAC_ARMED, SAC_SEARCH, SAC_DONE}
        sac_state_type;
    sac_state_type state_q; // Sequencer state
    logic start_q; // Start flip-flop
    logic shift_entry_flop; // Entry stage of the shift register
    logic [7:0] shift_q; // One-hot bit pointer, MSB first
    logic [7:0] result_q; // Held result
    logic [2:0] phase_q; // Divider to internal phase
    logic [3:0] set_cnt_q; // Remaining done set periods
    logic req; // Start request level
    logic phase_tick; // Internal phase clock edge
    logic rd_act; // Read access active
    logic launch; // Start flop clears and the search starts
    logic last_step; // Final bit is decided on this clock

    assign req = ~select_n & ~start_n;
    assign rd_act = ~select_n & ~read_n;
    assign phase_tick = (phase_q == 3'(PHASE_DIV - 1));
    // Launch waits for a phase edge once the request has gone away
    assign launch = start_q & shift_entry_flop & phase_tick & ~req;
    assign last_step = phase_tick & shift_q[0] & (state_q == SAC_SEARCH);

    // ****************************************************
    // Internal phase divider
    // ****************************************************
    // Free runs; an asynchronous release waits for the next phase edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            phase_q <= 3'h0;
        end else if (clk_en) begin
            phase_q <= phase_tick ? 3'h0 : phase_q + 3'h1;
        end
    end

    // ****************************************************
    // Start flip-flop and entry stage
    // ****************************************************
    // Set by the request; cleared on a phase edge only once it is gone
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            start_q <= 1'b0;
            shift_entry_flop <= 1'b0;
        end else if (clk_en) begin
            // Entry stage takes the 1 that a pending start offers
            shift_entry_flop <= req | start_q;
            if (req) begin
                start_q <= 1'b1;
            end else if (launch) begin
                // A clear pulse while the request stands has no effect
                start_q <= 1'b0;
            end
        end
    end

    // ****************************************************
    // Search sequencer
    // ****************************************************
    // One bit per phase edge: 8 bits x 8 clocks gives the 64-clock search
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= SAC_IDLE;
            shift_q <= 8'h00;
            trial_code_q <= 8'h00;
            result_q <= sac_pkg::RESULT_RST;
        end else if (clk_en) begin
            if (req || (start_q && !launch)) begin
                // Held in reset while the strobe is low; aborts a search
                state_q <= SAC_ARMED;
                shift_q <= 8'h00;
                trial_code_q <= 8'h00;
            end else if (phase_tick) begin
                unique case (state_q)
                    SAC_IDLE: begin
                        // Waits here for the next request
                        state_q <= SAC_IDLE;
                    end
                    SAC_ARMED: begin
                        if (shift_entry_flop) begin
                            state_q <= SAC_SEARCH;
                            shift_q <= 8'h80;
                            trial_code_q <= 8'h80;
                        end
                    end
                    SAC_SEARCH: begin
                        // Keep or drop the bit under test, try the next
                        if (!cmp_high || neg_ge_pos) begin
                            trial_code_q <= (trial_code_q & ~shift_q)
                                | (shift_q >> 1);
                        end else begin
                            trial_code_q <= trial_code_q | (shift_q >> 1);
                        end
                        shift_q <= shift_q >> 1;
                        if (shift_q[0]) begin
                            // Result moves to the latch before done asserts
                            result_q <= neg_ge_pos ? sac_pkg::ZERO_CODE
                                : (cmp_high ? trial_code_q
                                : trial_code_q & ~shift_q);
                            state_q <= SAC_DONE;
                        end
                    end
                    SAC_DONE: begin
                        state_q <= SAC_IDLE;
                    end
                endcase
            end
        end
    end

    // ****************************************************
    // Done set pulse
    // ****************************************************
    // Counts on every clock, phase edges included, so the set input stands
    // for exactly the set period; a new start cuts it short.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            set_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (req || start_q) begin
                // Any start ends the pulse at once
                set_cnt_q <= 4'h0;
            end else if (last_step) begin
                // Loaded on the clock that latches the result
                set_cnt_q <= 4'(sac_pkg::DONE_SET_CYCLES);
            end else if (set_cnt_q != 4'h0) begin
                set_cnt_q <= set_cnt_q - 4'h1;
            end
        end
    end

    // ****************************************************
    // Done flag
    // ****************************************************
    // Set pulse beats the read clear; a new request clears at once, so a
    // done output wired to the start strobe gives a one-cycle pulse.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            conversion_done_n_q <= 1'b1;
        end else if (clk_en) begin
            if (req || start_q) begin
                conversion_done_n_q <= 1'b1;
            end else if (set_cnt_q != 4'h0) begin
                conversion_done_n_q <= 1'b0;
            end else if (rd_act) begin
                conversion_done_n_q <= 1'b1;
            end
        end
    end

    // ****************************************************
    // Output latches
    // ****************************************************
    // Data lines driven only during a read; result kept until replaced
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            data_oe_q <= 1'b0;
            data_out_q <= sac_pkg::RESULT_RST;
        end else if (clk_en) begin
            data_oe_q <= rd_act;
            data_out_q <= result_q;
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    a_req_clears_done: assert property (@(posedge core_clk)
        disable iff (!nrst) (req && clk_en) |=> conversion_done_n_q)
        else $error("done not cleared by start");
    a_hold_in_reset: assert property (@(posedge core_clk)
        disable iff (!nrst) (req && clk_en) |=> (shift_q == 8'h00))
        else $error("shift register not held clear");
    a_start_kept: assert property (@(posedge core_clk)
        disable iff (!nrst) (req && clk_en) |=> start_q)
        else $error("start flop cleared during request");
    a_read_drives: assert property (@(posedge core_clk)
        disable iff (!nrst) (clk_en && rd_act) |=> data_oe_q)
        else $error("data not driven on read");
    a_no_read_float: assert property (@(posedge core_clk)
        disable iff (!nrst) (clk_en && !rd_act) |=> !data_oe_q)
        else $error("data driven without read");
    a_done_set_wins: assert property (@(posedge core_clk)
        disable iff (!nrst) (clk_en && set_cnt_q != 4'h0 && !req && !start_q)
        |=> !conversion_done_n_q)
        else $error("done set lost");
    a_zero_code: assert property (@(posedge core_clk)
        disable iff (!nrst) (clk_en && phase_tick && state_q == SAC_SEARCH
        && shift_q[0] && neg_ge_pos && !req && !start_q)
        |=> (result_q == sac_pkg::ZERO_CODE))
        else $error("nonzero code for negative input");
    a_done_after_latch: assert property (@(posedge core_clk)
        disable iff (!nrst) $fell(conversion_done_n_q)
        |-> $past(state_q) != SAC_SEARCH || $past(shift_q) == 8'h00)
        else $error("done before result latched");
endmodule
`default_nettype wire

//--- testbench/sac_cmp_model.sv
// Comparator and analog input model facing the conversion control.
// Assumes the trial code is registered, so the answer may be combinational.
`default_nettype none
module sac_cmp_model (
    input wire logic [7:0] trial_code, // Trial code from the control
    input wire logic [7:0] vin, // Analog input in code units
    output logic cmp_high // High while input at or above trial
);
    timeunit 1ns;
    timeprecision 1ns;
    // Answers within the same step, as a settled comparator would
    assign cmp_high = (vin >= trial_code);
endmodule
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the successive-approximation conversion control.
// Assumes a 25 MHz core clock and the comparator model beside the design.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, nrst, select_n, start_n, read_n, neg_ge_pos, free_run;
    logic [7:0] vin, trial_code_q, data_out_q, b;
    logic cmp_high, data_oe_q, conversion_done_n_q, start_w, prev_done;
    int err_total = 0;
    int total_checks = 0;
    int n, lows, falls;
    // Release-to-done window in negedge samples: 1 to 8 clocks to launch,
    // the search, whose last clock latches the result, then one clock to flag
    localparam int LAT_MIN = sac_pkg::CONV_CYCLES + 3;
    localparam int LAT_MAX = sac_pkg::CONV_CYCLES + 10;
    // Free running feeds done back to the start strobe
    assign start_w = free_run ? conversion_done_n_q : start_n;
    sac_ctrl dut_u (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1),
        .select_n(select_n), .start_n(start_w), .read_n(read_n),
        .cmp_high(cmp_high), .neg_ge_pos(neg_ge_pos),
        .trial_code_q(trial_code_q), .data_out_q(data_out_q),
        .data_oe_q(data_oe_q), .conversion_done_n_q(conversion_done_n_q));
    sac_cmp_model cmp_u (.trial_code(trial_code_q), .vin(vin),
        .cmp_high(cmp_high));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Hang guard, far beyond the planned run
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        results();
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // MSB first search against the same comparator relation
    function automatic logic [7:0] sar_ref(input logic [7:0] v,
        input logic neg);
        logic [7:0] t;
        t = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            t[i] = 1'b1;
            if (v < t) t[i] = 1'b0;
        end
        return neg ? 8'h00 : t;
    endfunction
    // Strobe low for w cycles; select stays low as simple logic may do
    task automatic kick(input int w);
        @(posedge core_clk);
        select_n <= 1'b0;
        start_n <= 1'b0;
        repeat (w) @(negedge core_clk);
        check({7'h00, conversion_done_n_q}, 8'h01);
        check(trial_code_q, 8'h00);
        @(posedge core_clk);
        start_n <= 1'b1;
    endtask
    task automatic wait_done();
        n = 0;
        while (conversion_done_n_q !== 1'b0 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        check({7'h00, n >= LAT_MIN && n <= LAT_MAX}, 8'h01);
    endtask
    task automatic convert(input int w, input logic [7:0] exp);
        kick(w);
        wait_done();
        repeat (10) @(posedge core_clk);
        read_n <= 1'b0;
        repeat (2) @(negedge core_clk);
        check({data_oe_q, conversion_done_n_q, 6'h00}, 8'hC0);
        check(data_out_q, exp);
        @(posedge core_clk);
        read_n <= 1'b1;
        select_n <= 1'b1;
        repeat (2) @(negedge core_clk);
        check({7'h00, data_oe_q}, 8'h00);
    endtask
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ************ Main sequence ************
    initial begin
        nrst = 1'b0;
        select_n = 1'b1;
        start_n = 1'b1;
        read_n = 1'b1;
        neg_ge_pos = 1'b0;
        free_run = 1'b0;
        vin = 8'h00;
        b = 8'h00;
        void'($urandom(32'h5E0C0F19));
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(negedge core_clk);
        check({data_oe_q, conversion_done_n_q, 6'h00}, 8'h40);
        // Corners first: full scale, zero, forced zero, wide strobe
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            vin <= b;
            neg_ge_pos <= (i == 2);
            convert((i == 3) ? 60 : 2, sar_ref(b, i == 2));
            $display("conversion %0d done", i);
        end
        // Restart in mid-search; only the second input may show
        @(posedge core_clk);
        neg_ge_pos <= 1'b0;
        vin <= 8'h3C;
        kick(2);
        repeat (30) @(posedge core_clk);
        vin <= 8'hA5;
        @(negedge core_clk);
        // The last completed result stays until a new one is latched
        check(data_out_q, sar_ref(b, 1'b0));
        convert(2, sar_ref(8'hA5, 1'b0));
        $display("abort test done");
        // Read held low throughout: done must still fall, hold 8 clocks, then clear
        kick(2);
        read_n <= 1'b0;
        wait_done();
        repeat (7) begin
            @(negedge core_clk);
            check({7'h00, conversion_done_n_q}, 8'h00);
        end
        @(negedge core_clk);
        check({7'h00, conversion_done_n_q}, 8'h01);
        check(data_out_q, 8'hA5);
        $display("continuous read test done");
        // Free running after one explicit start pulse
        @(posedge core_clk);
        read_n <= 1'b1;
        kick(2);
        free_run <= 1'b1;
        lows = 0;
        falls = 0;
        prev_done = 1'b1;
        repeat (600) begin
            @(negedge core_clk);
            if (conversion_done_n_q === 1'b0) lows++;
            if (conversion_done_n_q === 1'b0 && prev_done === 1'b1)
                falls++;
            prev_done = conversion_done_n_q;
        end
        check({7'h00, falls >= 3}, 8'h01);
        n = lows - falls * sac_pkg::FREE_PULSE_CYC;
        check({7'h00, n <= 0}, 8'h01);
        @(posedge core_clk);
        free_run <= 1'b0;
        select_n <= 1'b1;
        $display("free running test done");
        results();
    end
endmodule
`default_nettype wire
